// >>> i2cc_ctrl.v
/*
 Two-wire bus controller with a master function and a slave function,
 reached over APB. Pins are open drain: each pin has input, a constant
 low output and an active-low output enable.
 Assumes a pull-up on both bus lines outside the block.
*/
`timescale 1ns/1ns
`include "i2cc_consts.vh"
module i2cc_ctrl (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire serial_clock_pin_in,
  output wire serial_clock_pin_out,
  output wire serial_clock_pin_oe_n,
  input wire serial_data_pin_in,
  output wire serial_data_pin_out,
  output wire serial_data_pin_oe_n,
  output wire master_irq,
  output wire slave_irq
);
  localparam MS_IDLE = 3'b000;
  localparam MS_START = 3'b001;
  localparam MS_BYTE = 3'b010;
  localparam MS_STOP = 3'b011;
  localparam MS_HOLD = 3'b100;

  ////////////////////////////////////////////////////////////////////////
  // Pin sampling and bus monitor
  wire scl_s;
  wire sda_s;
  reg scl_p_q;
  reg sda_p_q;
  reg busy_q;

  i2cc_sync #(.RST_VAL(`I2CC_IDLE_LVL)) u_scl_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(serial_clock_pin_in),
    .dout(scl_s)
  );
  i2cc_sync #(.RST_VAL(`I2CC_IDLE_LVL)) u_sda_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(serial_data_pin_in),
    .dout(sda_s)
  );

  wire start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;
  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;
  wire bus_idle = scl_s & sda_s & ~busy_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_p_q <= `I2CC_IDLE_LVL;
      sda_p_q <= `I2CC_IDLE_LVL;
      busy_q <= 1'b0;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      if (start_det) begin
        busy_q <= 1'b1;
      end else if (stop_det) begin
        busy_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB decode
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire w_msa = wr & (paddr == `I2CC_MSA);
  wire w_mcs = wr & (paddr == `I2CC_MCS);
  wire w_mdr = wr & (paddr == `I2CC_MDR);
  wire w_mtpr = wr & (paddr == `I2CC_MTPR);
  wire w_mimr = wr & (paddr == `I2CC_MIMR);
  wire w_micr = wr & (paddr == `I2CC_MICR);
  wire w_mcr = wr & (paddr == `I2CC_MCR);
  wire w_soar = wr & (paddr == `I2CC_SOAR);
  wire w_sdr = wr & (paddr == `I2CC_SDR);
  wire w_simr = wr & (paddr == `I2CC_SIMR);
  wire w_sicr = wr & (paddr == `I2CC_SICR);
  wire r_sdr = rd & (paddr == `I2CC_SDR);

  ////////////////////////////////////////////////////////////////////////
  // Master registers and engine
  reg [2:0] mst_q;
  reg [3:0] ph_q;
  reg [3:0] bcnt_q;
  reg [7:0] ucnt_q;
  reg [7:0] msh_q;
  reg [7:0] msa_q;
  reg [7:0] mdr_q;
  reg [6:0] mtpr_q;
  reg [5:4] mcr_q;
  reg mimr_q;
  reg mris_q;
  reg m_done_q;
  reg samp_q;
  reg rep_q;
  reg rx_q;
  reg addr_q;
  reg stop_q;
  reg ack_q;
  reg err_q;
  reg adrack_q;
  reg datack_q;
  reg arb_q;
  reg m_sda_q;
  reg scl_want;
  reg sda_want;

  wire m_run = (mst_q != MS_IDLE) & (mst_q != MS_HOLD);
  wire cmd = w_mcs & mcr_q[`I2CC_CFG_MFE] & ~m_run;
  // high phase waits until the line is really high
  wire stretch = (ph_q >= `I2CC_LOW_PH) & ~scl_s;
  wire unit_end = (ucnt_q == {mtpr_q, 1'b1});
  wire tick = m_run & ~stretch & unit_end;
  wire ph_end = (ph_q == `I2CC_PH_LAST);
  // data frozen during first low unit
  wire m_sda_d = (m_run & (ph_q == `I2CC_PH_FIRST)) ? m_sda_q : sda_want;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ucnt_q <= 8'h00;
    end else if (~m_run | stretch | unit_end) begin
      ucnt_q <= 8'h00;
    end else begin
      ucnt_q <= ucnt_q + 8'h01;
    end
  end

  always @* begin
    scl_want = 1'b0;
    sda_want = 1'b0;
    case (mst_q)
      MS_START: begin
        scl_want = rep_q & (ph_q < `I2CC_LOW_PH);
        sda_want = (ph_q >= `I2CC_SAMPLE_PH);
      end
      MS_BYTE: begin
        scl_want = (ph_q < `I2CC_LOW_PH);
        if (bcnt_q == `I2CC_ACK_BIT) begin
          // receiver pulls, last byte left high
          sda_want = ~addr_q & rx_q & ack_q;
        end else begin
          sda_want = (addr_q | ~rx_q) & ~msh_q[7];
        end
      end
      MS_STOP: begin
        scl_want = (ph_q < `I2CC_LOW_PH);
        sda_want = (ph_q < `I2CC_SAMPLE_PH);
      end
      MS_HOLD: begin
        scl_want = 1'b1;
        sda_want = m_sda_q;
      end
      default: begin
        scl_want = 1'b0;
        sda_want = 1'b0;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mst_q <= MS_IDLE;
      ph_q <= `I2CC_PH_FIRST;
      bcnt_q <= 4'h0;
      msh_q <= 8'h00;
      msa_q <= 8'h00;
      mdr_q <= 8'h00;
      mtpr_q <= `I2CC_MTPR_RST;
      mcr_q <= 2'b00;
      mimr_q <= 1'b0;
      mris_q <= 1'b0;
      m_done_q <= 1'b0;
      samp_q <= 1'b1;
      rep_q <= 1'b0;
      rx_q <= 1'b0;
      addr_q <= 1'b0;
      stop_q <= 1'b0;
      ack_q <= 1'b0;
      err_q <= 1'b0;
      adrack_q <= 1'b0;
      datack_q <= 1'b0;
      arb_q <= 1'b0;
      m_sda_q <= 1'b0;
    end else begin
      m_sda_q <= m_sda_d;
      m_done_q <= 1'b0;
      if (w_msa) msa_q <= pwdata[7:0];
      if (w_mdr) mdr_q <= pwdata[7:0];
      // seven-bit timer spans standard and fast rates
      if (w_mtpr) mtpr_q <= pwdata[6:0];
      if (w_mcr) mcr_q <= pwdata[`I2CC_CFG_SFE:`I2CC_CFG_MFE];
      if (w_mimr) mimr_q <= pwdata[0];
      if (w_micr & pwdata[0]) mris_q <= 1'b0;
      if (m_done_q) mris_q <= 1'b1;
      if (cmd) begin
        stop_q <= pwdata[`I2CC_CMD_STOP];
        ack_q <= pwdata[`I2CC_CMD_ACK];
        ph_q <= `I2CC_PH_FIRST;
        bcnt_q <= 4'h0;
        if (pwdata[`I2CC_CMD_RUN] & pwdata[`I2CC_CMD_START]) begin
          // fresh start only on idle bus; repeated start
          if ((mst_q == MS_HOLD) | bus_idle) begin
            rep_q <= (mst_q == MS_HOLD);
            msh_q <= msa_q;
            rx_q <= msa_q[0];
            addr_q <= 1'b1;
            err_q <= 1'b0;
            adrack_q <= 1'b0;
            datack_q <= 1'b0;
            arb_q <= 1'b0;
            mst_q <= MS_START;
          end else begin
            // busy bus reported as lost arbitration
            err_q <= 1'b1;
            arb_q <= 1'b1;
            m_done_q <= 1'b1;
          end
        end else if (pwdata[`I2CC_CMD_RUN] & (mst_q == MS_HOLD)) begin
          msh_q <= mdr_q;
          addr_q <= 1'b0;
          err_q <= 1'b0;
          datack_q <= 1'b0;
          mst_q <= MS_BYTE;
        end else if (pwdata[`I2CC_CMD_STOP] & (mst_q == MS_HOLD)) begin
          mst_q <= MS_STOP;
        end
      end else if (tick) begin
        ph_q <= ph_end ? `I2CC_PH_FIRST : ph_q + 4'h1;
        case (mst_q)
          MS_START: begin
            if (ph_end) mst_q <= MS_BYTE;
          end
          MS_STOP: begin
            if (ph_end) begin
              mst_q <= MS_IDLE;
              m_done_q <= 1'b1;
            end
          end
          MS_BYTE: begin
            if ((ph_q == `I2CC_PH_FIRST) & (bcnt_q != 4'h0)) begin
              msh_q <= {msh_q[6:0], samp_q};
            end
            if (ph_q == `I2CC_SAMPLE_PH) begin
              samp_q <= sda_s;
              if ((bcnt_q != `I2CC_ACK_BIT) & (addr_q | ~rx_q) & msh_q[7] & ~sda_s) begin
                mst_q <= MS_IDLE;
                ph_q <= `I2CC_PH_FIRST;
                err_q <= 1'b1;
                arb_q <= 1'b1;
                m_done_q <= 1'b1;
              end
            end
            if (ph_end) begin
              if (bcnt_q != `I2CC_ACK_BIT) begin
                bcnt_q <= bcnt_q + 4'h1;
              end else begin
                bcnt_q <= 4'h0;
                if (addr_q) begin
                  if (samp_q) begin
                    // no address acknowledge: abort with stop
                    err_q <= 1'b1;
                    adrack_q <= 1'b1;
                    mst_q <= MS_STOP;
                  end else begin
                    addr_q <= 1'b0;
                    if (~rx_q) msh_q <= mdr_q;
                  end
                end else begin
                  if (rx_q) mdr_q <= msh_q;
                  if (~rx_q & samp_q) begin
                    err_q <= 1'b1;
                    datack_q <= 1'b1;
                    mst_q <= MS_STOP;
                  end else if (stop_q) begin
                    mst_q <= MS_STOP;
                  end else begin
                    // Clock held low until next command
                    mst_q <= MS_HOLD;
                    m_done_q <= 1'b1;
                  end
                end
              end
            end
          end
          default: mst_q <= mst_q;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Slave registers and engine
  reg [6:0] soar_q;
  reg [7:0] sdr_q;
  reg [7:0] ssh_q;
  reg [3:0] s_cnt_q;
  reg simr_q;
  reg sris_q;
  reg rreq_q;
  reg treq_q;
  reg fbr_q;
  reg s_first_q;
  reg s_addr_q;
  reg s_act_q;
  reg s_tx_q;
  reg s_nack_q;
  reg s_sda_low_q;
  reg s_hold_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soar_q <= 7'h00;
      sdr_q <= 8'h00;
      ssh_q <= 8'h00;
      s_cnt_q <= 4'h0;
      simr_q <= 1'b0;
      sris_q <= 1'b0;
      rreq_q <= 1'b0;
      treq_q <= 1'b0;
      fbr_q <= 1'b0;
      s_first_q <= 1'b0;
      s_addr_q <= 1'b0;
      s_act_q <= 1'b0;
      s_tx_q <= 1'b0;
      s_nack_q <= 1'b0;
      s_sda_low_q <= 1'b0;
      s_hold_q <= 1'b0;
    end else begin
      if (w_soar) soar_q <= pwdata[6:0];
      if (w_simr) simr_q <= pwdata[0];
      if (w_sicr & pwdata[0]) sris_q <= 1'b0;
      if (r_sdr & rreq_q) begin
        rreq_q <= 1'b0;
        fbr_q <= 1'b0;
        s_hold_q <= 1'b0;
      end
      if (w_sdr) begin
        sdr_q <= pwdata[7:0];
        if (treq_q) begin
          treq_q <= 1'b0;
          s_hold_q <= 1'b0;
          ssh_q <= pwdata[7:0];
          s_sda_low_q <= ~pwdata[7];
        end
      end
      if (start_det | ~mcr_q[`I2CC_CFG_SFE]) begin
        s_cnt_q <= 4'h0;
        s_addr_q <= 1'b1;
        s_act_q <= 1'b0;
        s_sda_low_q <= 1'b0;
        s_hold_q <= 1'b0;
      end else if (stop_det) begin
        s_addr_q <= 1'b0;
        s_act_q <= 1'b0;
        s_sda_low_q <= 1'b0;
        s_hold_q <= 1'b0;
      end else if (scl_rise) begin
        if (s_cnt_q != `I2CC_ACK_BIT) ssh_q <= {ssh_q[6:0], sda_s};
        else s_nack_q <= sda_s;
      end else if (scl_fall) begin
        if (s_cnt_q == `I2CC_LAST_DBIT) begin
          s_cnt_q <= `I2CC_ACK_BIT;
          if (s_addr_q) begin
            // address match; no match leaves data high
            if (ssh_q[7:1] == soar_q) begin
              s_act_q <= 1'b1;
              s_tx_q <= ssh_q[0];
              s_first_q <= 1'b1;
              s_sda_low_q <= 1'b1;
            end
          end else if (s_act_q & ~s_tx_q) begin
            // hold clock until software takes the byte
            sdr_q <= ssh_q;
            rreq_q <= 1'b1;
            fbr_q <= s_first_q;
            s_first_q <= 1'b0;
            sris_q <= 1'b1;
            s_sda_low_q <= 1'b1;
            s_hold_q <= 1'b1;
          end else if (s_act_q) begin
            s_sda_low_q <= 1'b0;
          end
        end else if (s_cnt_q == `I2CC_ACK_BIT) begin
          s_cnt_q <= 4'h0;
          s_addr_q <= 1'b0;
          s_sda_low_q <= 1'b0;
          if (s_act_q & s_tx_q) begin
            if (s_addr_q | ~s_nack_q) begin
              treq_q <= 1'b1;
              sris_q <= 1'b1;
              s_hold_q <= 1'b1;
            end else begin
              // master ended the read, stay released
              s_act_q <= 1'b0;
            end
          end
        end else begin
          s_cnt_q <= s_cnt_q + 4'h1;
          // slave data changes after the falling edge
          if (s_act_q & s_tx_q & ~s_addr_q) s_sda_low_q <= ~ssh_q[7];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pins, interrupts and read mux
  reg scl_oe_n_q;
  reg sda_oe_n_q;
  reg [31:0] rdata_d;
  reg hit_d;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_oe_n_q <= 1'b1;
      sda_oe_n_q <= 1'b1;
      prdata <= 32'h0000_0000;
    end else begin
      scl_oe_n_q <= ~(scl_want | s_hold_q);
      sda_oe_n_q <= ~(m_sda_d | s_sda_low_q);
      if (psel & ~penable) prdata <= rdata_d;
    end
  end

  assign serial_clock_pin_out = 1'b0;
  assign serial_data_pin_out = 1'b0;
  assign serial_clock_pin_oe_n = scl_oe_n_q;
  assign serial_data_pin_oe_n = sda_oe_n_q;
  // one line per function; raw AND mask
  assign master_irq = mris_q & mimr_q;
  assign slave_irq = sris_q & simr_q;
  assign pready = 1'b1;
  assign pslverr = acc & ~hit_d;

  always @* begin
    rdata_d = 32'h0000_0000;
    hit_d = 1'b1;
    case (paddr)
      `I2CC_MSA: rdata_d[7:0] = msa_q;
      `I2CC_MCS: rdata_d[6:0] = {busy_q, mst_q == MS_IDLE, arb_q, datack_q, adrack_q, err_q, m_run};
      `I2CC_MDR: rdata_d[7:0] = mdr_q;
      `I2CC_MTPR: rdata_d[6:0] = mtpr_q;
      `I2CC_MIMR: rdata_d[0] = mimr_q;
      // raw state visible whatever the mask
      `I2CC_MRIS: rdata_d[0] = mris_q;
      `I2CC_MMIS: rdata_d[0] = master_irq;
      `I2CC_MICR: rdata_d = 32'h0000_0000;
      `I2CC_MCR: rdata_d[5:4] = mcr_q;
      `I2CC_SOAR: rdata_d[6:0] = soar_q;
      `I2CC_SCSR: rdata_d[2:0] = {fbr_q, treq_q, rreq_q};
      `I2CC_SDR: rdata_d[7:0] = sdr_q;
      `I2CC_SIMR: rdata_d[0] = simr_q;
      `I2CC_SRIS: rdata_d[0] = sris_q;
      `I2CC_SMIS: rdata_d[0] = slave_irq;
      `I2CC_SICR: rdata_d = 32'h0000_0000;
      default: hit_d = 1'b0;
    endcase
  end
endmodule

// >>> i2cc_consts.vh
/*
 Constants for the two-wire bus controller: register offsets, field
 positions, reset values and serial clock phase factors.
 Assumes inclusion by bare name from the controller design files.
*/
`ifndef I2CC_CONSTS_VH
`define I2CC_CONSTS_VH

// Master register offsets
`define I2CC_MSA 12'h000
`define I2CC_MCS 12'h004
`define I2CC_MDR 12'h008
`define I2CC_MTPR 12'h00C
`define I2CC_MIMR 12'h010
`define I2CC_MRIS 12'h014
`define I2CC_MMIS 12'h018
`define I2CC_MICR 12'h01C
`define I2CC_MCR 12'h020
// Slave register offsets
`define I2CC_SOAR 12'h800
`define I2CC_SCSR 12'h804
`define I2CC_SDR 12'h808
`define I2CC_SIMR 12'h80C
`define I2CC_SRIS 12'h810
`define I2CC_SMIS 12'h814
`define I2CC_SICR 12'h818

// Command bits written to the master control/status register
`define I2CC_CMD_RUN 0
`define I2CC_CMD_START 1
`define I2CC_CMD_STOP 2
`define I2CC_CMD_ACK 3
// Master configuration bits
`define I2CC_CFG_MFE 4
`define I2CC_CFG_SFE 5

// Reset values
`define I2CC_MTPR_RST 7'h01
`define I2CC_IDLE_LVL 1'b1

// Serial clock phases, in units of 2*(1+timer) system clocks
`define I2CC_LOW_PH 4'h6
`define I2CC_HIGH_PH 4'h4
`define I2CC_PH_LAST (`I2CC_LOW_PH + `I2CC_HIGH_PH - 4'h1)
`define I2CC_SAMPLE_PH 4'h8
`define I2CC_PH_FIRST 4'h0
// Bit counter: eight data bits then the acknowledge bit
`define I2CC_LAST_DBIT 4'h7
`define I2CC_ACK_BIT 4'h8

`endif

// >>> i2cc_sync.v
/*
 Two-stage level synchroniser for one asynchronous input.
 Assumes the input is a pin outside the pclk domain.
*/
`timescale 1ns/1ns
module i2cc_sync #(
  parameter RST_VAL = 1'b1
) (
  input wire pclk,
  input wire presetn,
  input wire din,
  output wire dout
);
  reg meta_q;
  reg sync_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule

// >>> i2cc_slave_model.sv
/*
 Behavioural far-side slave for the two-wire bus: takes written bytes,
 acknowledges its own address and the bytes that follow, sends a fixed
 byte on reads until the master leaves one unacknowledged.
 Assumes open-drain lines with pull-ups resolved by the bench.
*/
`timescale 1ns/1ns
module i2cc_slave_model #(
  parameter [6:0] ADDR = 7'h3b,
  // Leads with zero so a wrong master acknowledge blocks the next start
  parameter [7:0] TXB = 8'h5c
) (
  input wire scl,
  input wire sda,
  output logic sda_oe_n,
  output logic [7:0] rx_addr,
  output logic [7:0] rx_data,
  output logic [3:0] nbytes
);
  logic [7:0] sh_q;
  logic act_q;
  logic hit_q;
  logic rd_q;
  logic tx_q;
  logic mack_q;
  integer bits = 0;
  initial begin
    sda_oe_n = 1'b1;
    nbytes = 4'h0;
    act_q = 1'b0;
    hit_q = 1'b0;
    rd_q = 1'b0;
    tx_q = 1'b0;
    mack_q = 1'b1;
    rx_addr = 8'h00;
    rx_data = 8'h00;
  end
  always @(negedge sda) if (scl === 1'b1) begin
    act_q = 1'b1;
    bits = 0;
    nbytes = 4'h0;
    rd_q = 1'b0;
    tx_q = 1'b0;
  end
  always @(posedge sda) if (scl === 1'b1) act_q = 1'b0;
  // sample while clock high, MSB first
  always @(posedge scl) begin
    if (act_q && bits < 8) begin
      sh_q = {sh_q[6:0], sda};
      bits = bits + 1;
    end else if (bits == 9) begin
      mack_q = sda;
    end
  end
  // ack own address and the written bytes after it; released line reads high
  always @(negedge scl) begin
    if (bits == 8) begin
      if (nbytes == 4'h0) begin
        rx_addr = sh_q;
        hit_q = (sh_q[7:1] == ADDR);
        rd_q = sh_q[0];
      end else if (!rd_q) begin
        rx_data = sh_q;
      end
      nbytes = nbytes + 4'h1;
      sda_oe_n = !hit_q || tx_q;
      bits = 9;
    end else if (bits == 9) begin
      bits = 0;
      // missing master acknowledge ends the read
      tx_q = hit_q && rd_q && !mack_q;
      sda_oe_n = !tx_q || TXB[7];
      if (!hit_q) act_q = 1'b0;
    end else if (tx_q && bits > 0) begin
      sda_oe_n = TXB[7 - bits];
    end
  end
endmodule

// >>> i2cc_ctrl_properties.sv
/*
 Concurrent checks on the controller's ports, bound into i2cc_ctrl.
 Assumes the register map of i2cc_consts.vh and a bench-held pull-up.
*/
`timescale 1ns/1ns
`include "i2cc_consts.vh"
module i2cc_ctrl_properties (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic pready,
  input logic [31:0] prdata,
  input logic pslverr,
  input logic serial_clock_pin_in,
  input logic serial_clock_pin_oe_n,
  input logic serial_data_pin_in,
  input logic serial_data_pin_oe_n,
  input logic master_irq
);
  logic [6:0] tim_q;
  logic mask_q;
  logic [15:0] lo_q;
  logic [15:0] hi_q;
  wire [15:0] tp1 = {9'h000, tim_q} + 16'h0001;
  wire wr_acc = psel & penable & pwrite;
  // Shadow of timer and mask, taken at the write edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tim_q <= `I2CC_MTPR_RST;
      mask_q <= 1'b0;
      lo_q <= 16'h0000;
      hi_q <= 16'h0000;
    end else begin
      if (wr_acc && paddr == `I2CC_MTPR) tim_q <= pwdata[6:0];
      if (wr_acc && paddr == `I2CC_MIMR) mask_q <= pwdata[0];
      lo_q <= serial_clock_pin_oe_n ? 16'h0000 : lo_q + 16'h0001;
      hi_q <= serial_clock_pin_oe_n ? hi_q + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence apb_acc;
    psel && penable;
  endsequence
  sequence lines_idle;
    $past(serial_data_pin_in) && $past(serial_clock_pin_in);
  endsequence
  pready_high_a: assert property (apb_acc |-> pready)
    else $error("pready low in access");
  unmapped_err_a: assert property (apb_acc ##0 (paddr > `I2CC_MCR && paddr < `I2CC_SOAR && !pwrite)
    |-> pslverr && prdata == 32'h0000_0000) else $error("unmapped read not refused");
  mapped_ok_a: assert property (apb_acc ##0 (paddr <= `I2CC_MCR && paddr[1:0] == 2'b00) |-> !pslverr)
    else $error("mapped access refused");
  err_idle_a: assert property (!(psel && penable) |-> !pslverr)
    else $error("pslverr outside access");
  irq_masked_a: assert property (!mask_q |-> !master_irq)
    else $error("interrupt while masked");
  irq_clear_a: assert property (apb_acc ##0 (pwrite && paddr == `I2CC_MICR && pwdata[0]) |=> !master_irq)
    else $error("interrupt not cleared");
  start_idle_a: assert property ($fell(serial_data_pin_oe_n) && serial_clock_pin_oe_n |-> lines_idle)
    else $error("start on busy bus");
  low_phase_a: assert property ($rose(serial_clock_pin_oe_n) |-> lo_q >= 16'd12 * tp1)
    else $error("clock low phase short");
  high_phase_a: assert property ($fell(serial_clock_pin_oe_n) |-> hi_q >= 16'd8 * tp1)
    else $error("clock high phase short");
endmodule
bind i2cc_ctrl i2cc_ctrl_properties i2cc_ctrl_properties_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .serial_clock_pin_in(serial_clock_pin_in), .serial_clock_pin_oe_n(serial_clock_pin_oe_n),
  .serial_data_pin_in(serial_data_pin_in), .serial_data_pin_oe_n(serial_data_pin_oe_n), .master_irq(master_irq));

// >>> test_i2c_master_slave_controller.sv
/*
 Self-checking bench: APB master, far-side slave model, fake rival master.
 Assumes pull-ups on both lines, modelled by AND of the enables.
*/
`timescale 1ns/1ns
`include "i2cc_consts.vh"
module test_i2c_master_slave_controller;
  logic pclk, presetn, psel, penable, pwrite, hold_q, err_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  wire pready, pslverr, scl_oe_n, sda_oe_n, slv_oe_n, master_irq, slave_irq;
  wire [31:0] prdata;
  wire [7:0] rx_addr, rx_data;
  wire [3:0] nbytes;
  integer error_cnt = 0, check_count = 0, cyc = 0;
  // Rival master pulls data low through hold_q
  wire scl_line = scl_oe_n;
  wire sda_line = sda_oe_n & slv_oe_n & !hold_q;
  i2cc_ctrl i2cc_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .serial_clock_pin_in(scl_line), .serial_clock_pin_out(), .serial_clock_pin_oe_n(scl_oe_n),
    .serial_data_pin_in(sda_line), .serial_data_pin_out(), .serial_data_pin_oe_n(sda_oe_n),
    .master_irq(master_irq), .slave_irq(slave_irq));
  i2cc_slave_model #(.ADDR(7'h3b)) i2cc_slave_model_i (.scl(scl_line), .sda(sda_line), .sda_oe_n(slv_oe_n),
    .rx_addr(rx_addr), .rx_data(rx_data), .nbytes(nbytes));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task results;
    $display("Checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      error_cnt = error_cnt + 1;
      $display("BAD %0t timeout", $time);
      results;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Ends when pready is high; only the bench timeout bounds this wait
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Raw flag polled, since it shows whatever the mask
  task wait_raw;
    apb(1'b0, `I2CC_MRIS, 32'h0000_0000);
    while (rd[0] !== 1'b1) begin
      apb(1'b0, `I2CC_MRIS, 32'h0000_0000);
    end
  endtask
  task wait_busbsy(input logic lvl);
    integer i;
    i = 0;
    apb(1'b0, `I2CC_MCS, 32'h0000_0000);
    while (rd[6] !== lvl && i < 20) begin
      i = i + 1;
      apb(1'b0, `I2CC_MCS, 32'h0000_0000);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_regs;
    apb(1'b0, `I2CC_MTPR, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    apb(1'b0, `I2CC_MRIS, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 12'h100, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(32'(err_q), 32'h0000_0001);
    $display("Test regs done");
  endtask
  task t_send;
    apb(1'b1, `I2CC_MCR, 32'h0000_0010);
    apb(1'b1, `I2CC_MSA, 32'h0000_0076);
    apb(1'b1, `I2CC_MDR, 32'h0000_00A5);
    apb(1'b1, `I2CC_MCS, 32'h0000_0003);
    wait_raw;
    chk(32'(rx_addr), 32'h0000_0076);
    chk(32'(rx_data), 32'h0000_00A5);
    chk(32'(master_irq), 32'h0000_0000);
    apb(1'b0, `I2CC_MCS, 32'h0000_0000);
    chk(rd & 32'h0000_0016, 32'h0000_0000);
    apb(1'b1, `I2CC_MICR, 32'h0000_0001);
    apb(1'b1, `I2CC_MIMR, 32'h0000_0001);
    apb(1'b1, `I2CC_MDR, 32'h0000_003C);
    apb(1'b1, `I2CC_MCS, 32'h0000_0005);
    wait_raw;
    chk(32'(master_irq), 32'h0000_0001);
    apb(1'b0, `I2CC_MMIS, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    chk(32'(nbytes), 32'h0000_0003);
    chk(32'(rx_data), 32'h0000_003C);
    apb(1'b0, `I2CC_MCS, 32'h0000_0000);
    chk(rd & 32'h0000_007F, 32'h0000_0020);
    apb(1'b1, `I2CC_MICR, 32'h0000_0001);
    @(posedge pclk);
    chk(32'(master_irq), 32'h0000_0000);
    chk(32'(slave_irq), 32'h0000_0000);
    $display("Test send done");
  endtask
  task t_recv;
    apb(1'b1, `I2CC_MSA, 32'h0000_0077);
    apb(1'b1, `I2CC_MCS, 32'h0000_000B);
    wait_raw;
    apb(1'b0, `I2CC_MDR, 32'h0000_0000);
    chk(rd, 32'h0000_005C);
    apb(1'b1, `I2CC_MICR, 32'h0000_0001);
    apb(1'b1, `I2CC_MCS, 32'h0000_0001);
    wait_raw;
    apb(1'b0, `I2CC_MDR, 32'h0000_0000);
    chk(rd, 32'h0000_005C);
    apb(1'b1, `I2CC_MICR, 32'h0000_0001);
    apb(1'b1, `I2CC_MSA, 32'h0000_0076);
    apb(1'b1, `I2CC_MDR, 32'h0000_005A);
    apb(1'b1, `I2CC_MCS, 32'h0000_0007);
    wait_raw;
    chk(32'({rx_addr, rx_data}), 32'h0000_765A);
    apb(1'b0, `I2CC_MCS, 32'h0000_0000);
    chk(rd & 32'h0000_007F, 32'h0000_0020);
    apb(1'b1, `I2CC_MICR, 32'h0000_0001);
    $display("Test recv done");
  endtask
  // Rival pulls data low after the address, while our data bit is one
  task t_arb;
    apb(1'b1, `I2CC_MDR, 32'h0000_0080);
    apb(1'b1, `I2CC_MCS, 32'h0000_0007);
    wait (nbytes == 4'h1);
    @(posedge pclk);
    hold_q <= 1'b1;
    wait_raw;
    apb(1'b0, `I2CC_MCS, 32'h0000_0000);
    chk(rd & 32'h0000_001F, 32'h0000_0012);
    chk(32'({scl_oe_n, sda_oe_n}), 32'h0000_0003);
    hold_q <= 1'b0;
    apb(1'b1, `I2CC_MICR, 32'h0000_0001);
    $display("Test arb done");
  endtask
  task t_nack;
    apb(1'b1, `I2CC_MSA, 32'h0000_0020);
    apb(1'b1, `I2CC_MCS, 32'h0000_0007);
    wait_raw;
    chk(32'(master_irq), 32'h0000_0001);
    apb(1'b0, `I2CC_MCS, 32'h0000_0000);
    chk(rd & 32'h0000_007F, 32'h0000_0026);
    chk(32'(nbytes), 32'h0000_0001);
    apb(1'b1, `I2CC_MICR, 32'h0000_0001);
    $display("Test nack done");
  endtask
  task t_busy;
    hold_q <= 1'b1;
    wait_busbsy(1'b1);
    chk(32'(rd[6]), 32'h0000_0001);
    apb(1'b1, `I2CC_MCS, 32'h0000_0003);
    wait_raw;
    apb(1'b0, `I2CC_MCS, 32'h0000_0000);
    chk(rd & 32'h0000_0012, 32'h0000_0012);
    chk(32'({scl_oe_n, sda_oe_n}), 32'h0000_0003);
    hold_q <= 1'b0;
    wait_busbsy(1'b0);
    chk(32'(rd[6]), 32'h0000_0000);
    apb(1'b1, `I2CC_MICR, 32'h0000_0001);
    $display("Test busy done");
  endtask
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    hold_q = 1'b0;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_send;
    t_recv;
    t_arb;
    t_nack;
    t_busy;
    results;
  end
endmodule
